// ===== verilog/wwdt_pkg.sv
// package: register map, field layout and reset values of the watchdog
package wwdt_pkg;
   localparam logic [1:0] OFS_RESTART_CTRL = 2'h0;
   localparam logic [1:0] OFS_MODE_CONFIG = 2'h1;
   localparam logic [1:0] OFS_FAULT_STATUS = 2'h2;
   localparam logic [3:0] ADDR_W = 4'h2;
   localparam int LOAD_LSB = 0;
   localparam int FIEN_BIT = 12;
   localparam int RSTEN_BIT = 13;
   localparam int SCOPE_BIT = 14;
   localparam int DIS_BIT = 15;
   localparam int DELTA_LSB = 16;
   localparam int DBGHLT_BIT = 28;
   localparam int IDLEHLT_BIT = 29;
   localparam int KEY_LSB = 24;
   localparam int RESTART_BIT = 0;
   localparam int UNF_BIT = 0;
   localparam int ERR_BIT = 1;
   localparam logic [7:0] RESTART_KEY = 8'hA5;
   localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
   localparam logic [11:0] COUNT_MAX = 12'hFFF;
   localparam int PRESCALE_DIV = 128;
   localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE_DIV - 1);
endpackage

// ===== verilog/wwdt_prescaler.sv
// divide-by-128 tick generator on the slow clock enable
`timescale 1ns/10ps
module wwdt_prescaler (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic slow_tick_in,
   input wire logic restart_in,
   output logic tick_out
);
   logic [6:0] count;
   logic [6:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count;
      next_tick = 1'b0;
      if (restart_in) begin
         next_count = 7'h00;
      end else if (slow_tick_in) begin
         if (count == wwdt_pkg::PRESCALE_LAST) begin
            next_count = 7'h00;
            next_tick = 1'b1;
         end else begin
            next_count = count + 7'h01;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         count <= 7'h00;
         tick_out <= 1'b0;
      end else begin
         count <= next_count;
         tick_out <= next_tick;
      end
   end
endmodule // wwdt_prescaler

// ===== verilog/wwdt_sync.sv
// three-stage synchroniser; a change counts when stages two and three agree
`timescale 1ns/10ps
module wwdt_sync (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic async_in,
   output logic level_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   always_comb begin
      next_stage = {stage[1:0], async_in};
      next_level = level_out;
      if (stage[1] == stage[2]) begin
         next_level = stage[2];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         stage <= 3'h0;
         level_out <= 1'b0;
      end else begin
         stage <= next_stage;
         level_out <= next_level;
      end
   end
endmodule // wwdt_sync

// ===== verilog/wwdt_core.sv
// windowed watchdog: write-once mode, keyed restart, sticky fault status
`timescale 1ns/10ps
module wwdt_core (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic slow_clk_in,
   input wire logic debug_state_in,
   input wire logic idle_mode_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   output logic fault_out,
   output logic proc_reset_req_out,
   output logic all_reset_req_out
);
   logic [31:0] mode;
   logic mode_locked;
   logic [11:0] count;
   logic underflow_flag;
   logic early_restart_error_flag;
   logic fault;
   logic slow_prev;
   logic [31:0] next_mode;
   logic next_locked;
   logic [11:0] next_count;
   logic next_unf;
   logic next_err;
   logic next_fault;
   logic [31:0] next_rdata;
   logic slow_sync;
   logic debug_sync;
   logic idle_sync;
   logic slow_rise;
   logic tick;
   logic restart_ok;
   logic restart_bad;
   logic mode_wr;
   logic ctrl_wr;
   logic stat_rd;
   logic halted;
   logic unf_event;

   function automatic logic hit(input logic [3:0] a, input logic [1:0] ofs);
      hit = (a == {ofs, 2'b00});
   endfunction

   wwdt_sync u_sync_slow (.mclk_in(mclk_in), .rst_in(rst_in),
      .async_in(slow_clk_in), .level_out(slow_sync));
   wwdt_sync u_sync_dbg (.mclk_in(mclk_in), .rst_in(rst_in),
      .async_in(debug_state_in), .level_out(debug_sync));
   wwdt_sync u_sync_idle (.mclk_in(mclk_in), .rst_in(rst_in),
      .async_in(idle_mode_in), .level_out(idle_sync));

   assign slow_rise = slow_sync & ~slow_prev;

   wire logic [11:0] load_val = mode[wwdt_pkg::LOAD_LSB +: 12];
   wire logic [11:0] delta_val = mode[wwdt_pkg::DELTA_LSB +: 12];
   wire logic disabled = mode[wwdt_pkg::DIS_BIT];
   wire logic rst_en = mode[wwdt_pkg::RSTEN_BIT];

   assign mode_wr = wr_in && hit(addr_in, wwdt_pkg::OFS_MODE_CONFIG);
   assign ctrl_wr = wr_in && hit(addr_in, wwdt_pkg::OFS_RESTART_CTRL)
      && wdata_in[wwdt_pkg::KEY_LSB +: 8] == wwdt_pkg::RESTART_KEY
      && wdata_in[wwdt_pkg::RESTART_BIT];
   assign stat_rd = rd_in && hit(addr_in, wwdt_pkg::OFS_FAULT_STATUS);
   // window check; delta at or above load always passes
   assign restart_ok = ctrl_wr && (count <= delta_val);
   assign restart_bad = ctrl_wr && (count > delta_val);
   assign halted = (debug_sync && mode[wwdt_pkg::DBGHLT_BIT])
      || (idle_sync && mode[wwdt_pkg::IDLEHLT_BIT]);

   wwdt_prescaler u_presc (.mclk_in(mclk_in), .rst_in(rst_in),
      .slow_tick_in(slow_rise & ~halted & ~disabled),
      .restart_in(restart_ok | (mode_wr & ~mode_locked)),
      .tick_out(tick));

   assign unf_event = tick && !disabled && !halted && count == 12'h000
      && !restart_ok && !(mode_wr && !mode_locked);

   always_comb begin
      next_mode = mode;
      next_locked = mode_locked;
      next_count = count;
      if (mode_wr && !mode_locked) begin
         next_mode = wdata_in;
         next_locked = 1'b1;
         next_count = wdata_in[wwdt_pkg::LOAD_LSB +: 12];
      end else if (restart_ok) begin
         next_count = load_val;
      end else if (tick && !disabled && !halted) begin
         // decrement and wrap from zero to the load value
         if (count == 12'h000) begin
            next_count = load_val;
         end else begin
            next_count = count - 12'h001;
         end
      end
   end

   always_comb begin
      next_unf = underflow_flag;
      next_err = early_restart_error_flag;
      if (stat_rd) begin
         next_unf = 1'b0;
         next_err = 1'b0;
      end
      // a new event wins over a clearing read
      if (unf_event) begin
         next_unf = 1'b1;
      end
      if (restart_bad) begin
         next_err = 1'b1;
      end
      next_fault = fault;
      if (stat_rd) begin
         next_fault = 1'b0;
      end
      if ((unf_event && rst_en) || restart_bad) begin
         next_fault = 1'b1;
      end
      next_rdata = 32'h0000_0000;
      if (rd_in && hit(addr_in, wwdt_pkg::OFS_MODE_CONFIG)) begin
         next_rdata = mode;
      end else if (stat_rd) begin
         next_rdata[wwdt_pkg::UNF_BIT] = underflow_flag;
         next_rdata[wwdt_pkg::ERR_BIT] = early_restart_error_flag;
      end
   end

   // a watchdog reset arrives back through rst_in, clearing all state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mode <= wwdt_pkg::MODE_RESET;
         mode_locked <= 1'b0;
         count <= wwdt_pkg::COUNT_MAX;
         underflow_flag <= 1'b0;
         early_restart_error_flag <= 1'b0;
         fault <= 1'b0;
         slow_prev <= 1'b0;
         rdata_out <= 32'h0000_0000;
         irq_out <= 1'b0;
         fault_out <= 1'b0;
         proc_reset_req_out <= 1'b0;
         all_reset_req_out <= 1'b0;
      end else begin
         mode <= next_mode;
         mode_locked <= next_locked;
         count <= next_count;
         underflow_flag <= next_unf;
         early_restart_error_flag <= next_err;
         fault <= next_fault;
         slow_prev <= slow_sync;
         rdata_out <= next_rdata;
         irq_out <= (next_unf | next_err)
            & next_mode[wwdt_pkg::FIEN_BIT];
         fault_out <= next_fault;
         proc_reset_req_out <= next_fault & next_mode[wwdt_pkg::RSTEN_BIT]
            & next_mode[wwdt_pkg::SCOPE_BIT];
         all_reset_req_out <= next_fault & next_mode[wwdt_pkg::RSTEN_BIT]
            & ~next_mode[wwdt_pkg::SCOPE_BIT];
      end
   end

   sequence s_unf_fault;
      unf_event && rst_en;
   endsequence

   // a clearing read with no new event in the same cycle
   sequence s_status_read;
      stat_rd && !unf_event && !restart_bad;
   endsequence

   // the first mode write after reset, the only one that lands
   sequence s_first_mode_wr;
      mode_wr && !mode_locked;
   endsequence

   // a prescaler tick that moves a nonzero count down by one
   sequence s_count_step;
      tick && !disabled && !halted && count != 12'h000
         && !restart_ok && !mode_wr;
   endsequence

   // a bad window restart with no tick beside it
   sequence s_bad_quiet;
      restart_bad && !tick;
   endsequence

   a_unf_sets_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
      unf_event |=> underflow_flag)
      else $error("underflow flag not set");
   a_unf_fault_out: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_unf_fault |=> fault_out)
      else $error("fault not raised on underflow");
   a_err_fault: assert property (@(posedge mclk_in) disable iff (rst_in)
      restart_bad |=> early_restart_error_flag && fault_out)
      else $error("early restart not flagged");
   a_restart_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
      restart_ok && !mode_wr |=> count == $past(load_val))
      else $error("restart did not reload");
   a_mode_locked: assert property (@(posedge mclk_in) disable iff (rst_in)
      mode_locked |=> $stable(mode))
      else $error("mode changed after lock");
   a_badkey_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
      wr_in && addr_in == 4'h0 && wdata_in[31:24] != 8'hA5
      |-> !restart_ok && !restart_bad)
      else $error("keyless write acted");
   a_halt_freeze: assert property (@(posedge mclk_in) disable iff (rst_in)
      halted && !ctrl_wr && !mode_wr |=> $stable(count))
      else $error("counter ran while halted");
   a_status_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_status_read |=> !fault_out && !irq_out
      ##1 (!fault_out || $past((unf_event && rst_en) || restart_bad)))
      else $error("status read did not clear");
   a_irq_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
      irq_out |-> (underflow_flag || early_restart_error_flag)
      && mode[wwdt_pkg::FIEN_BIT])
      else $error("interrupt without cause");

   // mode register: first write lands, locks and reloads
   a_mode_first_wr: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_first_mode_wr |=> mode == $past(wdata_in) && mode_locked)
      else $error("first mode write lost");
   a_mode_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_first_mode_wr
      |=> count == $past(wdata_in[wwdt_pkg::LOAD_LSB +: 12]))
      else $error("mode write did not reload");
   a_lock_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
      mode_locked |=> mode_locked)
      else $error("mode lock dropped");

   // counting, reload on underflow, freeze when disabled
   a_count_step: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_count_step |=> count == $past(count) - 12'h001)
      else $error("counter did not decrement");
   a_unf_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
      unf_event |=> count == $past(load_val))
      else $error("underflow did not reload");
   a_dis_freeze: assert property (@(posedge mclk_in) disable iff (rst_in)
      disabled && !restart_ok && !mode_wr |=> $stable(count))
      else $error("counter ran while disabled");
   a_restart_presc: assert property (@(posedge mclk_in) disable iff (rst_in)
      restart_ok |=> !tick)
      else $error("prescaler not restarted");
   a_bad_no_reload: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_bad_quiet |=> $stable(count))
      else $error("early restart reloaded");

   // sticky flags and the fault level
   a_unf_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
      underflow_flag && !stat_rd |=> underflow_flag)
      else $error("underflow flag dropped");
   a_err_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
      early_restart_error_flag && !stat_rd
      |=> early_restart_error_flag)
      else $error("error flag dropped");
   a_fault_level: assert property (@(posedge mclk_in) disable iff (rst_in)
      fault_out && !stat_rd |=> fault_out)
      else $error("fault level dropped");
   a_fault_cause: assert property (@(posedge mclk_in) disable iff (rst_in)
      $rose(fault_out) |-> $past((unf_event && rst_en) || restart_bad))
      else $error("fault without cause");
   a_irq_cause: assert property (@(posedge mclk_in) disable iff (rst_in)
      (underflow_flag || early_restart_error_flag)
      && mode[wwdt_pkg::FIEN_BIT] |-> irq_out)
      else $error("interrupt missing");

   // reset requests follow fault, enable and scope
   a_scope_proc: assert property (@(posedge mclk_in) disable iff (rst_in)
      proc_reset_req_out |-> fault_out && mode[wwdt_pkg::RSTEN_BIT]
      && mode[wwdt_pkg::SCOPE_BIT])
      else $error("processor reset request wrong");
   a_scope_all: assert property (@(posedge mclk_in) disable iff (rst_in)
      all_reset_req_out |-> fault_out && mode[wwdt_pkg::RSTEN_BIT]
      && !mode[wwdt_pkg::SCOPE_BIT])
      else $error("full reset request wrong");

   // read port: data one cycle after the strobe, zero otherwise
   a_rdata_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 32'h0000_0000)
      else $error("read data without read");
   a_stat_rdata: assert property (@(posedge mclk_in) disable iff (rst_in)
      stat_rd |=> rdata_out == {30'h0000_0000,
      $past(early_restart_error_flag), $past(underflow_flag)})
      else $error("status read data wrong");
   a_mode_rdata: assert property (@(posedge mclk_in) disable iff (rst_in)
      rd_in && hit(addr_in, wwdt_pkg::OFS_MODE_CONFIG)
      |=> rdata_out == $past(mode))
      else $error("mode read data wrong");
endmodule // wwdt_core

// ===== tb/wwdt_rstc_model.sv
// reset controller model: turns a watchdog reset request into a reset pulse
`timescale 1ns/10ps
module wwdt_rstc_model #(
   parameter int DELAY = 20
) (
   input wire logic mclk_in,
   input wire logic honour_in,
   input wire logic proc_req_in,
   input wire logic all_req_in,
   output logic reset_out
);
   int cnt = 0;
   initial reset_out = 1'b0;
   // pulse is four cycles long, after a settling delay
   always @(posedge mclk_in) begin
      if (cnt > 0) begin
         cnt <= cnt - 1;
         reset_out <= (cnt <= 4);
      end else begin
         reset_out <= 1'b0;
         if (honour_in && (proc_req_in || all_req_in)) begin
            cnt <= DELAY;
         end
      end
   end
endmodule // wwdt_rstc_model

// ===== tb/windowed_watchdog_timer_tb.sv
// self-checking bench for the windowed watchdog core
`timescale 1ns/10ps
module windowed_watchdog_timer_tb;
   logic mclk_in = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic dbg = 1'b0;
   logic idle = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic honour = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] key;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rv, pins;
   logic irq, fault, preq, areq, ctl_rst, rst_in;
   int n_fail = 0;
   int checks_done = 0;
   int mode_m, locked;
   assign rst_in = rst | ctl_rst;
   assign pins = {28'h0, irq, fault, preq, areq};
   wwdt_core u_wwdt_core (
      .mclk_in(mclk_in), .rst_in(rst_in), .slow_clk_in(slow),
      .debug_state_in(dbg), .idle_mode_in(idle), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .irq_out(irq), .fault_out(fault), .proc_reset_req_out(preq),
      .all_reset_req_out(areq)
   );
   wwdt_rstc_model u_wwdt_rstc_model (
      .mclk_in(mclk_in), .honour_in(honour), .proc_req_in(preq),
      .all_req_in(areq), .reset_out(ctl_rst)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr32(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 rv = rdata;
      chk(rv, e);
   endtask
   // model of the write-once mode register
   task automatic mw(input logic [31:0] d);
      wr32(4'h4, d);
      if (locked == 0) mode_m = d;
      locked = 1;
   endtask
   task automatic quiet(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge mclk_in);
         if (fault !== 1'b0) hits++;
      end
      chk(32'(hits), 32'h0);
   endtask
   task automatic waitf(input int n);
      int k;
      k = 0;
      while (fault !== 1'b1 && k < n) begin
         @(posedge mclk_in);
         k++;
      end
      #1 chk({31'h0, fault}, 32'h1);
   endtask
   task automatic conclude;
      $display("counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial forever #5 mclk_in = ~mclk_in;
   // one slow rising edge every four system cycles
   initial forever begin
      repeat (2) @(posedge mclk_in);
      slow <= ~slow;
   end
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
   initial begin
      void'($urandom(32'h3EC1465F));
      key = 8'hA5 ^ 8'($urandom_range(1, 255));
      mode_m = wwdt_pkg::MODE_RESET;
      locked = 0;
      repeat (6) @(posedge mclk_in);
      rst <= 1'b0;
      rchk(4'h4, mode_m);
      rchk(4'h8, 32'h0);
      wr32(4'h0, 32'hA500_0001);
      rchk(4'h8, 32'h0);
      $display("test defaults done");
      mw(32'h0002_7004);
      mw($urandom);
      rchk(4'h4, mode_m);
      wr32(4'h0, {key, 24'h000001});
      rchk(4'h8, 32'h0);
      wr32(4'h0, 32'hA500_0001);
      @(posedge mclk_in);
      #1 chk(pins, 32'hE);
      rchk(4'h8, 32'h2);
      @(posedge mclk_in);
      #1 chk(pins, 32'h0);
      $display("test early restart done");
      waitf(3000);
      repeat (10) @(posedge mclk_in);
      #1 chk(pins, 32'hE);
      rchk(4'h8, 32'h1);
      repeat (1280) @(posedge mclk_in);
      wr32(4'h0, 32'hA500_0001);
      rchk(4'h8, 32'h0);
      quiet(2300);
      waitf(500);
      rchk(4'h8, 32'h1);
      $display("test window done");
      @(posedge mclk_in);
      honour <= 1'b1;
      wr32(4'h0, 32'hA500_0001);
      repeat (40) @(posedge mclk_in);
      honour <= 1'b0;
      mode_m = wwdt_pkg::MODE_RESET;
      locked = 0;
      rchk(4'h8, 32'h0);
      rchk(4'h4, mode_m);
      $display("test fault reset done");
      mw(32'h3FFF_2002);
      @(posedge mclk_in);
      dbg <= 1'b1;
      quiet(2000);
      dbg <= 1'b0;
      idle <= 1'b1;
      quiet(2000);
      idle <= 1'b0;
      waitf(2000);
      chk(pins, 32'h5);
      rchk(4'h8, 32'h1);
      $display("test halt done");
      conclude();
   end
endmodule // windowed_watchdog_timer_tb
